// ===== design/pmc_pkg.sv
// Purpose: shared constants and types for the chip power mode controller
// Assumes: single 50 MHz clock domain
// Notes:   mode selection codes are software-facing values held outside the block
package pmc_pkg;

  // ------------------------------------------------------------
  // mode selection codes
  // ------------------------------------------------------------
  localparam logic [2:0] PMC_SEL_RUN   = 3'h0;
  localparam logic [2:0] PMC_SEL_HIGH_SPEED_RUN_MODE  = 3'h1;
  localparam logic [2:0] PMC_SEL_VERY_LOW_POWER_RUN_MODE  = 3'h2;
  localparam logic [2:0] PMC_SEL_STOP  = 3'h3;
  localparam logic [2:0] PMC_SEL_VERY_LOW_POWER_STOP_MODE  = 3'h4;
  localparam logic [2:0] PMC_SEL_LOW_LEAK_STOP_LEVEL3  = 3'h5;
  localparam logic [2:0] PMC_SEL_LOW_LEAK_STOP_LEVEL2  = 3'h6;

  // ------------------------------------------------------------
  // regulator and clock settings
  // ------------------------------------------------------------
  localparam logic [1:0] PMC_REG_FULL     = 2'h0;
  localparam logic [1:0] PMC_REG_LOWPOWER = 2'h1;
  localparam logic [1:0] PMC_REG_RETAIN   = 2'h2;

  localparam int PMC_CLK_HZ        = 50_000_000;
  localparam int PMC_FLASH_SLOW_HZ = 1_000_000;
  // divider from system clock to the reduced flash access rate
  localparam int PMC_FLASH_DIV     = PMC_CLK_HZ / PMC_FLASH_SLOW_HZ;

  // always-on peripheral clock mask bit positions
  localparam int PMC_PER_OSC    = 0;
  localparam int PMC_PER_LOW_POWER_TIMER  = 1;
  localparam int PMC_PER_LOW_POWER_SERIAL_PORT = 2;
  localparam int PMC_PER_RTC    = 3;
  localparam int PMC_PER_CMP    = 4;
  localparam int PMC_PER_TSI    = 5;
  localparam int PMC_PER_WAKE   = 6;
  localparam int PMC_PER_TPM    = 7;
  localparam int PMC_PER_W      = 9;
  localparam logic [8:0] PMC_PER_ALL = 9'h1FF;

  // sram power: bit0 upper 64 KB retained region, bit1 remainder
  localparam logic [1:0] PMC_SRAM_ALL = 2'h3;
  localparam logic [1:0] PMC_SRAM_64K = 2'h1;

  // ------------------------------------------------------------
  // state machine
  // ------------------------------------------------------------
  typedef enum logic [8:0] {
    PMC_ST_RUN  = 9'h001,
    PMC_ST_HIGH_SPEED_RUN_MODE = 9'h002,
    PMC_ST_WAIT = 9'h004,
    PMC_ST_STOP = 9'h008,
    PMC_ST_VERY_LOW_POWER_RUN_MODE = 9'h010,
    PMC_ST_VERY_LOW_POWER_WAIT_MODE = 9'h020,
    PMC_ST_VERY_LOW_POWER_STOP_MODE = 9'h040,
    PMC_ST_LOW_LEAK_STOP_LEVEL3 = 9'h080,
    PMC_ST_LOW_LEAK_STOP_LEVEL2 = 9'h100
  } pmc_state_e;

endpackage

// ===== design/pmc_power_mode_ctrl.sv
// Purpose: chip-level power mode sequencer
// Assumes: core sleep signals and wake events synchronous to clock
// Notes:   all outputs registered
//
// Overview of operation
// - after reset enter normal run with regulator fully on
// - wait and stop entered only on the core's wait-for-interrupt
// - normal and very-low-power run each have their own wait and stop
// - pin outputs held across every power mode
// - high-speed run: regulator full, max clock allowed, core high-speed state
// - normal wait: core sleeps, peripherals clocked, interrupt controller live
// - normal stop: deep sleep, peripheral clocks off, registers kept, voltage detect on
// - normal stop: interrupt controller off, async wake controller restores run
// - very-low-power run: low-power regulator, 1 MHz flash, voltage detect off
// - very-low-power run also allows external clock or crystal source
// - very-low-power wait: as run but core sleeps, core clock stays on
// - very-low-power stop: deep sleep, detect off, low-power regulator, adc and pins work
// - very-low-power stop keeps only low-power peripheral clocks running
// - very-low-power stop: core clock off, async wake controller wakes
// - very-low-power stop and leak stop 3 retain all sram
// - leak stops retain peripheral state, a few wake-capable units usable
// - leak stops: only the low-leak wake unit wakes the device
// - leak stop 2 keeps only 64 KB sram plus logic and pin state
// - leak stop recovery returns to normal run via wake unit service
`timescale 1ns/1ns
`default_nettype none

module pmc_power_mode_ctrl
  import pmc_pkg::*;
#(
  parameter int FLASH_DIV = PMC_FLASH_DIV
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic [2:0]       modeSelect,
  input  wire logic             extClkMode,
  input  wire logic             tpmSrcEn,
  input  wire logic             lpuartSrcEn,
  input  wire logic             coreSleep,
  input  wire logic             coreDeepSleep,
  input  wire logic             irqPending,
  input  wire logic             asyncWakeIrq,
  input  wire logic             leakWakeIrq,
  output logic [8:0]            powerMode,
  output logic                  coreHighSpeed,
  output logic                  coreClkEn,
  output logic                  irqCtrlEn,
  output logic                  asyncWakeEn,
  output logic                  leakWakeEn,
  output logic                  leakWakeVector,
  output logic [PMC_PER_W-1:0]  periphClkEn,
  output logic                  periphRetain,
  output logic [1:0]            regulatorState,
  output logic                  voltDetectEn,
  output logic                  flashSlowMode,
  output logic                  flashSlowTick,
  output logic                  extClkSelect,
  output logic [1:0]            sramPowerEn,
  output logic                  pinHold,
  output logic                  maxClkAllowed
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    pmc_state_e           st;
    logic [7:0]           divCnt;
    logic                 coreHighSpeed;
    logic                 coreClkEn;
    logic                 irqCtrlEn;
    logic                 asyncWakeEn;
    logic                 leakWakeEn;
    logic                 leakWakeVector;
    logic [PMC_PER_W-1:0] periphClkEn;
    logic                 periphRetain;
    logic [1:0]           regulatorState;
    logic                 voltDetectEn;
    logic                 flashSlowMode;
    logic                 flashSlowTick;
    logic                 extClkSelect;
    logic [1:0]           sramPowerEn;
    logic                 pinHold;
    logic                 maxClkAllowed;
  } pmc_state_s;

  pmc_state_s s_q;
  pmc_state_s s_d;

  // ------------------------------------------------------------
  // sleep request
  // ------------------------------------------------------------
  logic sleepReq;
  assign sleepReq = coreSleep | coreDeepSleep;

  // ------------------------------------------------------------
  // next state and output decode
  // ------------------------------------------------------------
  always_comb begin
    pmc_state_e nx;
    nx = s_q.st;
    s_d = s_q;
    s_d.leakWakeVector = 1'b0;
    case (s_q.st)
      PMC_ST_RUN: begin
        if (sleepReq) begin
          case (modeSelect)
            PMC_SEL_STOP: nx = PMC_ST_STOP;
            PMC_SEL_VERY_LOW_POWER_STOP_MODE: nx = PMC_ST_VERY_LOW_POWER_STOP_MODE;
            PMC_SEL_LOW_LEAK_STOP_LEVEL3: nx = PMC_ST_LOW_LEAK_STOP_LEVEL3;
            PMC_SEL_LOW_LEAK_STOP_LEVEL2: nx = PMC_ST_LOW_LEAK_STOP_LEVEL2;
            default:      nx = PMC_ST_WAIT;
          endcase
        end else if (modeSelect == PMC_SEL_HIGH_SPEED_RUN_MODE) begin
          nx = PMC_ST_HIGH_SPEED_RUN_MODE;
        end else if (modeSelect == PMC_SEL_VERY_LOW_POWER_RUN_MODE) begin
          nx = PMC_ST_VERY_LOW_POWER_RUN_MODE;
        end
      end
      PMC_ST_HIGH_SPEED_RUN_MODE: begin
        // sleep from high-speed run drops to normal run first
        if (sleepReq || modeSelect != PMC_SEL_HIGH_SPEED_RUN_MODE) begin
          nx = PMC_ST_RUN;
        end
      end
      PMC_ST_WAIT: begin
        if (irqPending) begin
          nx = PMC_ST_RUN;
        end
      end
      PMC_ST_STOP: begin
        if (asyncWakeIrq) begin
          nx = PMC_ST_RUN;
        end
      end
      PMC_ST_VERY_LOW_POWER_RUN_MODE: begin
        if (sleepReq) begin
          if (coreDeepSleep || modeSelect == PMC_SEL_VERY_LOW_POWER_STOP_MODE) begin
            nx = PMC_ST_VERY_LOW_POWER_STOP_MODE;
          end else begin
            nx = PMC_ST_VERY_LOW_POWER_WAIT_MODE;
          end
        end else if (modeSelect == PMC_SEL_RUN) begin
          nx = PMC_ST_RUN;
        end
      end
      PMC_ST_VERY_LOW_POWER_WAIT_MODE: begin
        if (irqPending) begin
          nx = PMC_ST_VERY_LOW_POWER_RUN_MODE;
        end
      end
      PMC_ST_VERY_LOW_POWER_STOP_MODE: begin
        if (asyncWakeIrq) begin
          // return level follows the selection still held at wake
          nx = (modeSelect == PMC_SEL_VERY_LOW_POWER_STOP_MODE) ? PMC_ST_VERY_LOW_POWER_RUN_MODE : PMC_ST_RUN;
        end
      end
      PMC_ST_LOW_LEAK_STOP_LEVEL3, PMC_ST_LOW_LEAK_STOP_LEVEL2: begin
        if (leakWakeIrq) begin
          nx = PMC_ST_RUN;
          // one-cycle pulse steers the core into the wake unit service
          s_d.leakWakeVector = 1'b1;
        end
      end
      default: nx = PMC_ST_RUN;
    endcase
    s_d.st = nx;

    // ----------------------------------------------------------
    // per-mode controls, normal run by default
    // ----------------------------------------------------------
    s_d.coreHighSpeed  = 1'b0;
    s_d.coreClkEn      = 1'b1;
    s_d.irqCtrlEn      = 1'b1;
    s_d.asyncWakeEn    = 1'b0;
    s_d.leakWakeEn     = 1'b0;
    s_d.periphClkEn    = PMC_PER_ALL;
    s_d.periphRetain   = 1'b0;
    s_d.regulatorState = PMC_REG_FULL;
    s_d.voltDetectEn   = 1'b1;
    s_d.flashSlowMode  = 1'b0;
    s_d.extClkSelect   = 1'b0;
    s_d.sramPowerEn    = PMC_SRAM_ALL;
    s_d.pinHold        = 1'b1;
    s_d.maxClkAllowed  = 1'b0;
    case (nx)
      PMC_ST_HIGH_SPEED_RUN_MODE: begin
        s_d.coreHighSpeed = 1'b1;
        s_d.maxClkAllowed = 1'b1;
      end
      PMC_ST_WAIT: begin
        s_d.coreClkEn = 1'b0;
      end
      PMC_ST_STOP: begin
        s_d.coreClkEn   = 1'b0;
        s_d.periphClkEn = '0;
        s_d.irqCtrlEn   = 1'b0;
        s_d.asyncWakeEn = 1'b1;
      end
      PMC_ST_VERY_LOW_POWER_RUN_MODE, PMC_ST_VERY_LOW_POWER_WAIT_MODE: begin
        s_d.regulatorState = PMC_REG_LOWPOWER;
        s_d.voltDetectEn   = 1'b0;
        s_d.flashSlowMode  = 1'b1;
        s_d.extClkSelect   = extClkMode;
      end
      PMC_ST_VERY_LOW_POWER_STOP_MODE: begin
        s_d.coreClkEn      = 1'b0;
        s_d.irqCtrlEn      = 1'b0;
        s_d.asyncWakeEn    = 1'b1;
        s_d.regulatorState = PMC_REG_LOWPOWER;
        s_d.voltDetectEn   = 1'b0;
        s_d.extClkSelect   = extClkMode;
        s_d.periphClkEn    = '0;
        s_d.periphClkEn[PMC_PER_OSC]    = 1'b1;
        s_d.periphClkEn[PMC_PER_LOW_POWER_TIMER]  = 1'b1;
        s_d.periphClkEn[PMC_PER_LOW_POWER_SERIAL_PORT] = lpuartSrcEn;
        s_d.periphClkEn[PMC_PER_RTC]    = 1'b1;
        s_d.periphClkEn[PMC_PER_CMP]    = 1'b1;
        s_d.periphClkEn[PMC_PER_TSI]    = 1'b1;
        s_d.periphClkEn[PMC_PER_TPM]    = tpmSrcEn;
        s_d.sramPowerEn    = PMC_SRAM_ALL;
      end
      PMC_ST_LOW_LEAK_STOP_LEVEL3, PMC_ST_LOW_LEAK_STOP_LEVEL2: begin
        s_d.coreClkEn      = 1'b0;
        s_d.irqCtrlEn      = 1'b0;
        s_d.leakWakeEn     = 1'b1;
        s_d.periphRetain   = 1'b1;
        s_d.regulatorState = PMC_REG_RETAIN;
        s_d.periphClkEn    = '0;
        s_d.periphClkEn[PMC_PER_OSC]   = 1'b1;
        s_d.periphClkEn[PMC_PER_WAKE]  = 1'b1;
        s_d.periphClkEn[PMC_PER_LOW_POWER_TIMER] = 1'b1;
        s_d.periphClkEn[PMC_PER_RTC]   = 1'b1;
        s_d.periphClkEn[PMC_PER_CMP]   = 1'b1;
        s_d.periphClkEn[PMC_PER_TSI]   = 1'b1;
        s_d.sramPowerEn = (nx == PMC_ST_LOW_LEAK_STOP_LEVEL2) ? PMC_SRAM_64K : PMC_SRAM_ALL;
      end
      default: begin
      end
    endcase

    // ----------------------------------------------------------
    // reduced-rate flash strobe in very-low-power run
    // ----------------------------------------------------------
    s_d.flashSlowTick = 1'b0;
    if (s_d.flashSlowMode) begin
      if (s_q.divCnt == 8'(FLASH_DIV - 1)) begin
        s_d.divCnt        = 8'h00;
        s_d.flashSlowTick = 1'b1;
      end else begin
        s_d.divCnt = s_q.divCnt + 8'h01;
      end
    end else begin
      s_d.divCnt = 8'h00;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_q                <= '0;
      s_q.st             <= PMC_ST_RUN;
      s_q.coreClkEn      <= 1'b1;
      s_q.irqCtrlEn      <= 1'b1;
      s_q.periphClkEn    <= PMC_PER_ALL;
      s_q.regulatorState <= PMC_REG_FULL;
      s_q.voltDetectEn   <= 1'b1;
      s_q.sramPowerEn    <= PMC_SRAM_ALL;
      s_q.pinHold        <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign powerMode      = s_q.st;
  assign coreHighSpeed  = s_q.coreHighSpeed;
  assign coreClkEn      = s_q.coreClkEn;
  assign irqCtrlEn      = s_q.irqCtrlEn;
  assign asyncWakeEn    = s_q.asyncWakeEn;
  assign leakWakeEn     = s_q.leakWakeEn;
  assign leakWakeVector = s_q.leakWakeVector;
  assign periphClkEn    = s_q.periphClkEn;
  assign periphRetain   = s_q.periphRetain;
  assign regulatorState = s_q.regulatorState;
  assign voltDetectEn   = s_q.voltDetectEn;
  assign flashSlowMode  = s_q.flashSlowMode;
  assign flashSlowTick  = s_q.flashSlowTick;
  assign extClkSelect   = s_q.extClkSelect;
  assign sramPowerEn    = s_q.sramPowerEn;
  assign pinHold        = s_q.pinHold;
  assign maxClkAllowed  = s_q.maxClkAllowed;

endmodule

`default_nettype wire

// ===== bench/pmc_props.sv
// Purpose: checker for the power mode controller ports
// Assumes: one clock, sync active-high reset
// Notes:   bound into every controller instance
`timescale 1ns/1ns
`default_nettype none
module pmc_props
  import pmc_pkg::*;
#(
  parameter int FLASH_DIV = PMC_FLASH_DIV
) (
  input wire logic             clock,
  input wire logic             sys_rst,
  input wire logic             coreSleep,
  input wire logic             coreDeepSleep,
  input wire logic             tpmSrcEn,
  input wire logic             lpuartSrcEn,
  input wire logic [8:0]       powerMode,
  input wire logic             coreHighSpeed,
  input wire logic             coreClkEn,
  input wire logic             irqCtrlEn,
  input wire logic             asyncWakeEn,
  input wire logic             leakWakeEn,
  input wire logic             leakWakeVector,
  input wire logic [PMC_PER_W-1:0] periphClkEn,
  input wire logic             periphRetain,
  input wire logic [1:0]       regulatorState,
  input wire logic             voltDetectEn,
  input wire logic             flashSlowMode,
  input wire logic             flashSlowTick,
  input wire logic [1:0]       sramPowerEn,
  input wire logic             pinHold,
  input wire logic             maxClkAllowed
);
  // ----------------------------------------
  // helpers and assertions
  // ----------------------------------------
  logic [7:0] gapQ;
  logic       inLls;
  assign inLls = powerMode[7] | powerMode[8];
  always_ff @(posedge clock) begin
    gapQ <= (sys_rst || flashSlowTick || !flashSlowMode) ? 8'h00 : gapQ + 8'h01;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  property p_rst; $fell(sys_rst) |-> powerMode == PMC_ST_RUN && regulatorState == PMC_REG_FULL; endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_entry; (powerMode & 9'h1EC) != 0 && ($past(powerMode) & 9'h013) != 0
    |-> $past(coreSleep | coreDeepSleep); endproperty
  a_entry: assert property (p_entry) else $error("low power entry without sleep");
  property p_pins; pinHold; endproperty
  a_pins: assert property (p_pins) else $error("pin hold dropped");
  property p_high_speed_run_mode; powerMode == PMC_ST_HIGH_SPEED_RUN_MODE |-> coreHighSpeed && maxClkAllowed
    && regulatorState == PMC_REG_FULL; endproperty
  a_high_speed_run_mode: assert property (p_high_speed_run_mode) else $error("high speed run outputs wrong");
  property p_wait; powerMode == PMC_ST_WAIT |-> irqCtrlEn && !coreClkEn && periphClkEn == PMC_PER_ALL; endproperty
  a_wait: assert property (p_wait) else $error("wait outputs wrong");
  property p_stop; powerMode == PMC_ST_STOP |-> !irqCtrlEn && asyncWakeEn && periphClkEn == 9'h000 && voltDetectEn
    && sramPowerEn == PMC_SRAM_ALL; endproperty
  a_stop: assert property (p_stop) else $error("stop outputs wrong");
  property p_very_low_power_run_mode; powerMode == PMC_ST_VERY_LOW_POWER_RUN_MODE |-> regulatorState == PMC_REG_LOWPOWER
    && flashSlowMode && !voltDetectEn; endproperty
  a_very_low_power_run_mode: assert property (p_very_low_power_run_mode) else $error("vlp run outputs wrong");
  property p_tick; flashSlowMode |-> gapQ <= FLASH_DIV; endproperty
  a_tick: assert property (p_tick) else $error("flash tick late");
  property p_very_low_power_wait_mode; powerMode == PMC_ST_VERY_LOW_POWER_WAIT_MODE |-> coreClkEn && irqCtrlEn
    && regulatorState == PMC_REG_LOWPOWER; endproperty
  a_very_low_power_wait_mode: assert property (p_very_low_power_wait_mode) else $error("vlp wait outputs wrong");
  property p_very_low_power_stop_mode; powerMode == PMC_ST_VERY_LOW_POWER_STOP_MODE |-> !coreClkEn && !irqCtrlEn && asyncWakeEn && !voltDetectEn
    && regulatorState == PMC_REG_LOWPOWER && sramPowerEn == PMC_SRAM_ALL; endproperty
  a_very_low_power_stop_mode: assert property (p_very_low_power_stop_mode) else $error("vlp stop outputs wrong");
  property p_vclk; powerMode == PMC_ST_VERY_LOW_POWER_STOP_MODE && $stable(tpmSrcEn) && $stable(lpuartSrcEn)
    |-> periphClkEn == {1'b0, tpmSrcEn, 1'b0, 3'h7, lpuartSrcEn, 2'h3}; endproperty
  a_vclk: assert property (p_vclk) else $error("vlp stop clocks wrong");
  property p_lls; inLls |-> leakWakeEn && !irqCtrlEn && !asyncWakeEn && periphRetain
    && periphClkEn == 9'h07B; endproperty
  a_lls: assert property (p_lls) else $error("leak stop outputs wrong");
  property p_sram; inLls |-> sramPowerEn == (powerMode[8] ? PMC_SRAM_64K : PMC_SRAM_ALL); endproperty
  a_sram: assert property (p_sram) else $error("leak stop sram wrong");
  property p_exit; powerMode == PMC_ST_RUN && $past(inLls) && !$past(sys_rst) |-> leakWakeVector && irqCtrlEn;
    endproperty
  a_exit: assert property (p_exit) else $error("leak stop exit wrong");
  c_low_leak_stop_level2: cover property (powerMode == PMC_ST_LOW_LEAK_STOP_LEVEL2);
  c_very_low_power_stop_mode: cover property (powerMode == PMC_ST_VERY_LOW_POWER_STOP_MODE);
  c_high_speed_run_mode: cover property (powerMode == PMC_ST_HIGH_SPEED_RUN_MODE);
endmodule
bind pmc_power_mode_ctrl pmc_props #(.FLASH_DIV(FLASH_DIV)) pmc_props_i (.clock, .sys_rst, .coreSleep,
  .coreDeepSleep, .tpmSrcEn, .lpuartSrcEn, .powerMode, .coreHighSpeed, .coreClkEn, .irqCtrlEn, .asyncWakeEn,
  .leakWakeEn, .leakWakeVector, .periphClkEn, .periphRetain, .regulatorState, .voltDetectEn, .flashSlowMode,
  .flashSlowTick, .sramPowerEn, .pinHold, .maxClkAllowed);
`default_nettype wire

// ===== bench/pmc_core_model.sv
// Purpose: core and wake-source model
// Assumes: commands from the bench, one cycle each
// Notes:   sleep level holds until a wake event reaches the core
`timescale 1ns/1ns
`default_nettype none
module pmc_core_model (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic [1:0] sleepCmd,
  input  wire logic [2:0] wakeCmd,
  output logic            coreSleep,
  output logic            coreDeepSleep,
  output logic            irqPending,
  output logic            asyncWakeIrq,
  output logic            leakWakeIrq
);
  // ----------------------------------------
  // sleep level and wake lines
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst || wakeCmd != 3'h0) begin
      coreSleep     <= 1'b0;
      coreDeepSleep <= 1'b0;
    end else if (sleepCmd != 2'h0) begin
      coreSleep     <= sleepCmd[0];
      coreDeepSleep <= sleepCmd[1];
    end
  end
  // leak wake interrupt never masked
  assign irqPending   = wakeCmd[0];
  assign asyncWakeIrq = wakeCmd[1];
  assign leakWakeIrq  = wakeCmd[2];
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// Purpose: self-checking bench for the power mode controller
// Assumes: 50 MHz clock, sync reset
// Notes:   short flash divider
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import pmc_pkg::*;
  localparam int DIV = 4;
  logic       clock = 1'b0;
  logic       sys_rst = 1'b1;
  logic [2:0] modeSelect = 3'h0;
  logic       extClkMode = 1'b1;
  logic       tpmSrcEn = 1'b1;
  logic       lpuartSrcEn = 1'b0;
  logic [1:0] sleepCmd = 2'h0;
  logic [2:0] wakeCmd = 3'h0;
  wire logic  coreSleep, coreDeepSleep, irqPending, asyncWakeIrq, leakWakeIrq;
  logic [8:0] powerMode, periphClkEn;
  logic [1:0] regulatorState, sramPowerEn;
  logic       coreHighSpeed, leakWakeVector, flashSlowTick, extClkSelect;
  int         miscompares = 0;
  int         totalChecks = 0;
  always #10 clock = ~clock;
  pmc_core_model pmc_core_model_i (.clock, .sys_rst, .sleepCmd, .wakeCmd, .coreSleep, .coreDeepSleep,
    .irqPending, .asyncWakeIrq, .leakWakeIrq);
  pmc_power_mode_ctrl #(.FLASH_DIV(DIV)) pmc_power_mode_ctrl_i (.clock, .sys_rst, .modeSelect, .extClkMode,
    .tpmSrcEn, .lpuartSrcEn, .coreSleep, .coreDeepSleep, .irqPending, .asyncWakeIrq, .leakWakeIrq, .powerMode,
    .coreHighSpeed, .coreClkEn(), .irqCtrlEn(), .asyncWakeEn(), .leakWakeEn(), .leakWakeVector, .periphClkEn,
    .periphRetain(), .regulatorState, .voltDetectEn(), .flashSlowMode(), .flashSlowTick, .extClkSelect,
    .sramPowerEn, .pinHold(), .maxClkAllowed());
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic report_and_stop();
    if (miscompares == 0 && totalChecks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(string name, logic [8:0] exp, logic [8:0] got);
    totalChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic go(logic [2:0] sel, logic [1:0] slp, logic [2:0] wk);
    @(posedge clock);
    modeSelect <= sel;
    sleepCmd <= slp;
    wakeCmd <= wk;
    @(posedge clock);
    sleepCmd <= 2'h0;
    wakeCmd <= 3'h0;
  endtask
  task automatic await(logic [8:0] exp);
    int n = 0;
    @(negedge clock);
    while (powerMode !== exp && n < 8) begin
      @(negedge clock);
      n++;
    end
    chk("powerMode", exp, powerMode);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_sleep();
    logic [2:0] sel [5] = '{PMC_SEL_RUN, PMC_SEL_STOP, PMC_SEL_VERY_LOW_POWER_STOP_MODE, PMC_SEL_LOW_LEAK_STOP_LEVEL3, PMC_SEL_LOW_LEAK_STOP_LEVEL2};
    logic [8:0] st [5] = '{PMC_ST_WAIT, PMC_ST_STOP, PMC_ST_VERY_LOW_POWER_STOP_MODE, PMC_ST_LOW_LEAK_STOP_LEVEL3, PMC_ST_LOW_LEAK_STOP_LEVEL2};
    logic [2:0] wk [5] = '{3'h1, 3'h2, 3'h2, 3'h4, 3'h4};
    for (int i = 0; i < 5; i++) begin
      go(sel[i], 2'h0, 3'h0);
      await(PMC_ST_RUN);
      go(sel[i], (i == 0) ? 2'h1 : 2'h3, 3'h0);
      await(st[i]);
      go(sel[i], 2'h0, wk[i] ^ 3'h7);
      repeat (2) @(negedge clock);
      chk("heldMode", st[i], powerMode);
      go((i == 2) ? PMC_SEL_RUN : sel[i], 2'h0, wk[i]);
      await(PMC_ST_RUN);
      chk("leakWakeVector", {8'h00, i > 2}, {8'h00, leakWakeVector});
    end
  endtask
  task automatic t_high_speed_run_mode();
    go(PMC_SEL_HIGH_SPEED_RUN_MODE, 2'h0, 3'h0);
    await(PMC_ST_HIGH_SPEED_RUN_MODE);
    chk("coreHighSpeed", 9'h001, {8'h00, coreHighSpeed});
    chk("regulatorState", {7'h00, PMC_REG_FULL}, {7'h00, regulatorState});
    go(PMC_SEL_RUN, 2'h0, 3'h0);
    await(PMC_ST_RUN);
  endtask
  task automatic t_vlp();
    int n = 0;
    go(PMC_SEL_VERY_LOW_POWER_RUN_MODE, 2'h0, 3'h0);
    await(PMC_ST_VERY_LOW_POWER_RUN_MODE);
    chk("extClkSelect", 9'h001, {8'h00, extClkSelect});
    repeat (20) begin
      @(negedge clock);
      if (flashSlowTick === 1'b1) n++;
    end
    chk("flashTicks", 9'(20 / DIV), n[8:0]);
    go(PMC_SEL_VERY_LOW_POWER_RUN_MODE, 2'h1, 3'h0);
    await(PMC_ST_VERY_LOW_POWER_WAIT_MODE);
    go(PMC_SEL_VERY_LOW_POWER_RUN_MODE, 2'h0, 3'h1);
    await(PMC_ST_VERY_LOW_POWER_RUN_MODE);
    go(PMC_SEL_VERY_LOW_POWER_STOP_MODE, 2'h3, 3'h0);
    await(PMC_ST_VERY_LOW_POWER_STOP_MODE);
    chk("periphClkEn", 9'h0BB, periphClkEn);
    go(PMC_SEL_VERY_LOW_POWER_STOP_MODE, 2'h0, 3'h2);
    await(PMC_ST_VERY_LOW_POWER_RUN_MODE);
    go(PMC_SEL_RUN, 2'h0, 3'h0);
    await(PMC_ST_RUN);
  endtask
  task automatic t_alt();
    @(posedge clock);
    extClkMode <= 1'b0;
    lpuartSrcEn <= 1'b1;
    tpmSrcEn <= 1'b0;
    go(PMC_SEL_VERY_LOW_POWER_RUN_MODE, 2'h0, 3'h0);
    await(PMC_ST_VERY_LOW_POWER_RUN_MODE);
    chk("extClkSelect", 9'h000, {8'h00, extClkSelect});
    go(PMC_SEL_VERY_LOW_POWER_RUN_MODE, 2'h2, 3'h0);
    await(PMC_ST_VERY_LOW_POWER_STOP_MODE);
    chk("periphClkEn", 9'h03F, periphClkEn);
    go(PMC_SEL_RUN, 2'h0, 3'h2);
    await(PMC_ST_RUN);
    go(PMC_SEL_LOW_LEAK_STOP_LEVEL2, 2'h2, 3'h0);
    await(PMC_ST_LOW_LEAK_STOP_LEVEL2);
    chk("sramPowerEn", {7'h00, PMC_SRAM_64K}, {7'h00, sramPowerEn});
    @(posedge clock);
    sys_rst <= 1'b1;
    @(posedge clock);
    sys_rst <= 1'b0;
    @(negedge clock);
    chk("powerMode", PMC_ST_RUN, powerMode);
    chk("regulatorState", {7'h00, PMC_REG_FULL}, {7'h00, regulatorState});
    chk("sramPowerEn", {7'h00, PMC_SRAM_ALL}, {7'h00, sramPowerEn});
  endtask
  initial begin
    repeat (3000) @(posedge clock);
    miscompares++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    @(negedge clock);
    chk("powerMode", PMC_ST_RUN, powerMode);
    chk("sramPowerEn", {7'h00, PMC_SRAM_ALL}, {7'h00, sramPowerEn});
    t_sleep();
    t_high_speed_run_mode();
    t_vlp();
    t_alt();
    report_and_stop();
  end
endmodule
`default_nettype wire
